//--- hw/dpr_pkg.sv
// shared constants and types of the dual-port RAM port logic
package dpr_pkg;
	// array organisation
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int LANES  = 4;
	localparam int LANE_W = 9;
	localparam int PORTS  = 2;
	localparam int EVT_W  = 4;

	// mailbox locations, left port owns the lower one
	localparam logic [17:0] MBOX_LEFT_ADDR  = 18'h3FFFE;
	localparam logic [17:0] MBOX_RIGHT_ADDR = 18'h3FFFF;

	// counter reset values and increment step
	localparam logic [17:0] COUNT_RESET = 18'h00000;
	localparam logic [17:0] MASK_RESET  = 18'h3FFFF;
	localparam logic [17:0] COUNT_STEP  = 18'h00001;

	// register port offsets and reset values
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK   = 4'h4;
	localparam logic [3:0] REG_STATE  = 4'h8;
	localparam logic [3:0] STATUS_RESET   = 4'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// event bit positions: wrap bits by port, then mailbox bits by port
	localparam int EVT_WRAP_BASE = 0;
	localparam int EVT_MBOX_BASE = 2;

	// per-cycle counter operation decoded from the control pins
	typedef enum logic [2:0] {
		OP_HOLD      = 3'b000,
		OP_INCR      = 3'b001,
		OP_LOAD_CNT  = 3'b010,
		OP_LOAD_MASK = 3'b011,
		OP_CLEAR     = 3'b100,
		OP_READBACK  = 3'b101
	} dpr_cnt_op_t;

	typedef enum logic {
		RB_IDLE  = 1'b0,
		RB_DRIVE = 1'b1
	} dpr_rb_state_t;

	// pins a host drives into one port
	typedef struct packed {
		logic        chip_select_active_low;
		logic        chip_select_active_high;
		logic        read_not_write;
		logic        output_drive_enable_n;
		logic [3:0]  byte_lane_enables_n;
		logic        address_load_strobe_n;
		logic        counter_advance_n;
		logic        counter_clear_n;
		logic        counter_or_mask_select;
		logic [17:0] address_in;
		logic [35:0] data_in;
	} dpr_port_in_t;

	// pins one port drives back
	typedef struct packed {
		logic [35:0] data_out;
		logic        data_oe;
		logic [17:0] address_out;
		logic        address_oe;
		logic        counter_wrap_flag_n;
		logic        mailbox_flag_n;
	} dpr_port_out_t;

	// access captured at the clock edge
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  be_n;
		logic [17:0] addr;
		logic [35:0] data;
	} dpr_stage_t;
endpackage

//--- hw/dpr_mailbox.sv
// mailbox flags passing messages between the two ports
`timescale 1ns/1ns
module dpr_mailbox (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] set_req,
	input  wire logic [1:0] clear_req,
	output logic      [1:0] flag_n
);
	logic [1:0] next_flag_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	for (genvar i = 0; i < dpr_pkg::PORTS; i++) begin : g_flag
		// set by writer edge, cleared by reader edge
		// set beats clear so a message posted during the read is kept
		always_comb begin
			if (set_req[i]) begin
				next_flag_n[i] = 1'b0;
			end else if (clear_req[i]) begin
				next_flag_n[i] = 1'b1;
			end else begin
				next_flag_n[i] = flag_n[i];
			end
		end

		a_mbox_set_wins: assert property (set_req[i] |=> !flag_n[i])
			else $error("mailbox flag not raised by write");
		a_mbox_read_clears: assert property (
			(clear_req[i] && !set_req[i]) |=> flag_n[i] ##1 (flag_n[i] || $past(set_req[i])))
			else $error("mailbox flag not cleared by read");
	end

	// flags idle high after reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flag_n <= 2'b11;
		end else begin
			flag_n <= next_flag_n;
		end
	end
endmodule

//--- hw/dpr_counter.sv
// burst address counter, mask register and readback of one port
`timescale 1ns/1ns
module dpr_counter (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  dpr_pkg::dpr_port_in_t pin,
	output logic        [17:0] access_addr,
	output logic        [17:0] address_out,
	output logic               address_oe,
	output logic               counter_wrap_flag_n,
	output logic               wrap_event
);
	dpr_pkg::dpr_cnt_op_t   op;
	dpr_pkg::dpr_rb_state_t rb_state;
	dpr_pkg::dpr_rb_state_t next_rb_state;
	logic [17:0] count;
	logic [17:0] next_count;
	logic [17:0] mask;
	logic [17:0] next_mask;
	logic [17:0] origin;
	logic [17:0] next_origin;
	logic [17:0] next_address_out;
	logic [17:0] bumped;
	logic        at_max;
	logic        next_wrap_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// decode; clear has priority and never stalls the access
	always_comb begin
		if (!pin.counter_clear_n) begin
			op = dpr_pkg::OP_CLEAR;
		end else if (!pin.address_load_strobe_n && !pin.counter_advance_n) begin
			op = pin.counter_or_mask_select ? dpr_pkg::OP_LOAD_CNT : dpr_pkg::OP_LOAD_MASK;
		end else if (!pin.address_load_strobe_n) begin
			op = dpr_pkg::OP_READBACK;
		end else if (!pin.counter_advance_n) begin
			op = dpr_pkg::OP_INCR;
		end else begin
			op = dpr_pkg::OP_HOLD;
		end
	end

	// next counter state; on increment only the unmasked bits move
	always_comb begin
		bumped = (count & ~mask) | ((count + dpr_pkg::COUNT_STEP) & mask);
		at_max = (count & mask) == mask;
		next_count = count;
		next_mask = mask;
		next_origin = origin;
		next_wrap_n = counter_wrap_flag_n;
		next_address_out = address_out;
		next_rb_state = dpr_pkg::RB_IDLE;
		unique case (op)
			dpr_pkg::OP_CLEAR: begin
				next_count = dpr_pkg::COUNT_RESET;
				next_origin = dpr_pkg::COUNT_RESET;
				next_wrap_n = 1'b1;
			end
			dpr_pkg::OP_LOAD_CNT: begin
				next_count = pin.address_in;
				next_origin = pin.address_in;
				next_wrap_n = 1'b1;
			end
			dpr_pkg::OP_LOAD_MASK: begin
				next_mask = pin.address_in;
				next_wrap_n = 1'b1;
			end
			dpr_pkg::OP_INCR: begin
				next_count = at_max ? origin : bumped;
				next_wrap_n = (next_count & mask) != mask;
			end
			// latch counter or mask for the address lines
			dpr_pkg::OP_READBACK: begin
				next_address_out = pin.counter_or_mask_select ? count : mask;
				next_rb_state = dpr_pkg::RB_DRIVE;
			end
			dpr_pkg::OP_HOLD: begin
			end
		endcase
		wrap_event = (op == dpr_pkg::OP_INCR) && !next_wrap_n && counter_wrap_flag_n;
	end

	// the access of this edge uses the updated address
	assign access_addr = next_count;
	// drive only the cycle after a readback edge
	assign address_oe = (rb_state == dpr_pkg::RB_DRIVE);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= dpr_pkg::COUNT_RESET;
			mask <= dpr_pkg::MASK_RESET;
			origin <= dpr_pkg::COUNT_RESET;
			counter_wrap_flag_n <= 1'b1;
			address_out <= dpr_pkg::COUNT_RESET;
			rb_state <= dpr_pkg::RB_IDLE;
		end else begin
			count <= next_count;
			mask <= next_mask;
			origin <= next_origin;
			counter_wrap_flag_n <= next_wrap_n;
			address_out <= next_address_out;
			rb_state <= next_rb_state;
		end
	end

	sequence s_rb_end;
		op == dpr_pkg::OP_READBACK ##1 op != dpr_pkg::OP_READBACK;
	endsequence

	a_load_counter: assert property (op == dpr_pkg::OP_LOAD_CNT |=>
		count == $past(pin.address_in)) else $error("counter not loaded");
	a_wrap_flag_low: assert property (
		(op == dpr_pkg::OP_INCR && !at_max && (bumped & mask) == mask)
		|=> !counter_wrap_flag_n) else $error("wrap flag not asserted");
	a_retransmit_origin: assert property ((op == dpr_pkg::OP_INCR && at_max)
		|=> count == $past(origin)) else $error("counter missed retransmit");
	a_readback_value: assert property (op == dpr_pkg::OP_READBACK |=>
		address_oe && address_out == $past(pin.counter_or_mask_select ? count : mask))
		else $error("readback value wrong");
	a_readback_release: assert property (s_rb_end |=> !address_oe)
		else $error("address lines not released");
endmodule

//--- hw/dpr_port_logic.sv
// port logic of the synchronous dual-port RAM: array, pipelines, flags
`timescale 1ns/1ns

// Overview of operation
// - counter clear never stalls a same-cycle access
// - address lines released after readback, host resumes
// - readback shows counter or mask per select
// - cross-port write seen by reader next cycle
// - too little clock skew gives undefined reads; here both ports share one clock and a read gets the same-edge write
// - wrap flag driven, low at masked maximum
// - counting past wrap repeats the loaded block
// - top address is right port mailbox
// - flag set by writer, cleared by reader
// - output enable gates data lines without clock
// - chip select effect appears one cycle later
// - all other inputs sampled at rising edge
// - load strobe plus advance loads counter or mask per select
module dpr_port_logic (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  global_clear_n,
	input  dpr_pkg::dpr_port_in_t      left_in,
	input  dpr_pkg::dpr_port_in_t      right_in,
	output dpr_pkg::dpr_port_out_t     left_out,
	output dpr_pkg::dpr_port_out_t     right_out,
	input  wire logic            [3:0] reg_address,
	input  wire logic           [31:0] reg_write_data,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic                [31:0] reg_read_data,
	output logic                       irq
);
	logic                      rst_n;
	dpr_pkg::dpr_port_in_t     pin [2];
	dpr_pkg::dpr_port_out_t    pout [2];
	dpr_pkg::dpr_stage_t       s1 [2];
	dpr_pkg::dpr_stage_t       next_s1 [2];
	logic               [35:0] dout [2];
	logic               [35:0] next_dout [2];
	logic               [35:0] rd_word [2];
	logic                [1:0] drive;
	logic                [1:0] next_drive;
	logic                [1:0] selected;
	logic                [1:0] wrap_flag_n;
	logic                [1:0] wrap_event;
	logic                [1:0] mbox_set;
	logic                [1:0] mbox_clear;
	logic                [1:0] mbox_flag_n;
	logic               [17:0] access_addr [2];
	logic               [17:0] rb_addr [2];
	logic                [1:0] rb_oe;
	logic                [3:0] status;
	logic                [3:0] next_status;
	logic                [3:0] irq_mask;
	logic                [3:0] next_irq_mask;
	logic                [3:0] events;
	logic               [31:0] next_read_data;

	// the array itself, one word per address
	logic [35:0] mem [0:(1 << dpr_pkg::ADDR_W) - 1];

	// master clear joins the system reset; both act at the clock edge
	assign rst_n = reset_n & global_clear_n;

	assign pin[0] = left_in;
	assign pin[1] = right_in;
	assign left_out = pout[0];
	assign right_out = pout[1];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	for (genvar p = 0; p < dpr_pkg::PORTS; p++) begin : g_port
		localparam int Q = 1 - p;
		localparam logic [17:0] MBOX_ADDR =
			(p == 0) ? dpr_pkg::MBOX_LEFT_ADDR : dpr_pkg::MBOX_RIGHT_ADDR;

		// burst counter, mask and readback of this port
		dpr_counter u_counter (
			.clk                 (clk),
			.reset_n             (rst_n),
			.pin                 (pin[p]),
			.access_addr         (access_addr[p]),
			.address_out         (rb_addr[p]),
			.address_oe          (rb_oe[p]),
			.counter_wrap_flag_n (wrap_flag_n[p]),
			.wrap_event          (wrap_event[p])
		);

		// capture the access at the rising edge
		always_comb begin
			selected[p] = !pin[p].chip_select_active_low
				&& pin[p].chip_select_active_high;
			next_s1[p].valid = selected[p];
			next_s1[p].write = !pin[p].read_not_write;
			next_s1[p].be_n = pin[p].byte_lane_enables_n;
			next_s1[p].addr = access_addr[p];
			next_s1[p].data = pin[p].data_in;
		end

		// read data with the other port's write of the same edge
		// both ports share one clock, so skew is always met
		always_comb begin
			rd_word[p] = mem[s1[p].addr];
			for (int l = 0; l < dpr_pkg::LANES; l++) begin
				if (s1[Q].valid && s1[Q].write && !s1[Q].be_n[l]
					&& s1[Q].addr == s1[p].addr) begin
					rd_word[p][l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] =
						s1[Q].data[l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
				end
			end
		end

		// read data and deselect show one cycle on
		always_comb begin
			next_drive[p] = s1[p].valid && !s1[p].write;
			next_dout[p] = next_drive[p] ? rd_word[p] : dout[p];
		end

		// mailbox writes by the far port, reads by this one
		always_comb begin
			mbox_set[p] = s1[Q].valid && s1[Q].write
				&& s1[Q].addr == MBOX_ADDR && s1[Q].be_n != 4'hF;
			mbox_clear[p] = s1[p].valid && !s1[p].write
				&& s1[p].addr == MBOX_ADDR && s1[p].be_n != 4'hF;
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				s1[p] <= '0;
				dout[p] <= 36'h000000000;
				drive[p] <= 1'b0;
			end else begin
				s1[p] <= next_s1[p];
				dout[p] <= next_dout[p];
				drive[p] <= next_drive[p];
			end
		end

		// pins of this port
		always_comb begin
			pout[p].data_out = dout[p];
			// output enable acts with no clock in the path
			pout[p].data_oe = drive[p] && !pin[p].output_drive_enable_n;
			pout[p].address_out = rb_addr[p];
			pout[p].address_oe = rb_oe[p];
			// the wrap flag is a plain driven level, never floated
			pout[p].counter_wrap_flag_n = wrap_flag_n[p];
			pout[p].mailbox_flag_n = mbox_flag_n[p];
		end

		sequence s_read_issue;
			selected[p] && pin[p].read_not_write;
		endsequence

		sequence s_collide;
			s1[p].valid && !s1[p].write && s1[Q].valid && s1[Q].write
			&& s1[Q].be_n == 4'h0 && s1[Q].addr == s1[p].addr;
		endsequence

		a_clear_access: assert property (
			(!pin[p].counter_clear_n && selected[p]) |=>
			s1[p].valid && s1[p].addr == dpr_pkg::COUNT_RESET)
			else $error("access lost during counter clear");
		a_read_latency: assert property (
			s_read_issue |-> ##2 drive[p])
			else $error("read data not two edges on");
		a_deselect_latency: assert property (
			!selected[p] |-> ##2 !drive[p])
			else $error("deselect not one cycle later");
		a_oe_async: assert property (
			pin[p].output_drive_enable_n |-> !pout[p].data_oe)
			else $error("data lines driven while disabled");
		a_cross_forward: assert property (
			s_collide |=> dout[p] == $past(s1[Q].data))
			else $error("reader missed new write data");

		// a write drives no data two edges on
		a_write_no_drive: assert property (
			(selected[p] && !pin[p].read_not_write) |-> ##2 !drive[p])
			else $error("data driven after a write");

		a_data_hold: assert property (
			!(s1[p].valid && !s1[p].write) |=> $stable(pout[p].data_out))
			else $error("read data moved without a read");

		// enabled output drives while read data stand
		a_oe_follows: assert property (
			(drive[p] && !pin[p].output_drive_enable_n) |-> pout[p].data_oe)
			else $error("data not driven while enabled");

		// flag pin follows the far port's write
		a_mbox_flag_pin: assert property (
			mbox_set[p] |=> !pout[p].mailbox_flag_n)
			else $error("mailbox pin not raised");

		// flag pin released by this port's read
		a_mbox_clear_pin: assert property (
			(mbox_clear[p] && !mbox_set[p]) |=> pout[p].mailbox_flag_n)
			else $error("mailbox pin not released");

		// a full word lands at the edge after sampling
		// a same-address double write is undefined, so it is left out
		a_write_lands: assert property (
			(s1[p].valid && s1[p].write && s1[p].be_n == 4'h0
			&& !(s1[Q].valid && s1[Q].write && s1[Q].addr == s1[p].addr))
			|=> mem[$past(s1[p].addr)] == $past(s1[p].data))
			else $error("write missing from array");
	end

	// write port of the array; both ports may write in one edge
	// a same-address collision is undefined, the right port lands last
	always_ff @(posedge clk) begin
		for (int w = 0; w < dpr_pkg::PORTS; w++) begin
			for (int l = 0; l < dpr_pkg::LANES; l++) begin
				if (s1[w].valid && s1[w].write && !s1[w].be_n[l]) begin
					mem[s1[w].addr][l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] <=
						s1[w].data[l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
				end
			end
		end
	end

	// mailbox flags of both ports
	dpr_mailbox u_mailbox (
		.clk       (clk),
		.reset_n   (rst_n),
		.set_req   (mbox_set),
		.clear_req (mbox_clear),
		.flag_n    (mbox_flag_n)
	);

	// events that latch into the status register
	assign events = {mbox_set, wrap_event};

	// status is write-one-to-clear; a new event wins over the clear
	always_comb begin
		next_status = status;
		next_irq_mask = irq_mask;
		if (reg_write && reg_address == dpr_pkg::REG_STATUS) begin
			next_status = status & ~reg_write_data[3:0];
		end
		if (reg_write && reg_address == dpr_pkg::REG_MASK) begin
			next_irq_mask = reg_write_data[3:0];
		end
		next_status = next_status | events;
	end

	// read data stand in the cycle after the strobe only
	always_comb begin
		next_read_data = 32'h00000000;
		if (reg_read) begin
			unique case (reg_address)
				dpr_pkg::REG_STATUS: next_read_data = {28'h0000000, status};
				dpr_pkg::REG_MASK:   next_read_data = {28'h0000000, irq_mask};
				dpr_pkg::REG_STATE:  next_read_data = {28'h0000000, mbox_flag_n, wrap_flag_n};
				default:             next_read_data = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status <= dpr_pkg::STATUS_RESET;
			irq_mask <= dpr_pkg::IRQ_MASK_RESET;
			reg_read_data <= 32'h00000000;
		end else begin
			status <= next_status;
			irq_mask <= next_irq_mask;
			reg_read_data <= next_read_data;
		end
	end

	// level interrupt while any unmasked event is pending
	assign irq = |(status & irq_mask);

	// register port: sticky events, one-to-clear, mask, read pulse
	a_status_sticky: assert property (
		(|events) |=> (status & $past(events)) == $past(events))
		else $error("event not latched");

	a_status_clear: assert property (
		(reg_write && reg_address == dpr_pkg::REG_STATUS && events == 4'h0)
		|=> (status & $past(reg_write_data[3:0])) == 4'h0)
		else $error("status not cleared by a one");

	a_mask_write: assert property (
		(reg_write && reg_address == dpr_pkg::REG_MASK)
		|=> irq_mask == $past(reg_write_data[3:0]))
		else $error("mask not written");

	a_read_idle_zero: assert property (
		!reg_read |=> reg_read_data == 32'h00000000)
		else $error("read data outside read cycle");

	// state register shows the live flag pins
	a_state_read: assert property (
		(reg_read && reg_address == dpr_pkg::REG_STATE)
		|=> reg_read_data[3:0] == $past({mbox_flag_n, wrap_flag_n}))
		else $error("state register wrong");
endmodule

//--- verif/dpr_host.sv
// host bus master model for one port of the dual-port RAM
`timescale 1ns/1ns
module dpr_host (
	input  wire logic              clk,
	output dpr_pkg::dpr_port_in_t  pin,
	input  dpr_pkg::dpr_port_out_t pout
);
	dpr_pkg::dpr_port_in_t p;
	logic                  drive;
	logic                  was_rb;
	logic           [17:0] bus;
	logic           [17:0] last_bus;

	// address wire: device readback first, then host, else a drifting float
	assign bus = pout.address_oe ? pout.address_out : (drive ? p.address_in : ~last_bus);

	// the port sees the resolved address wire, not the host's intent
	always_comb begin
		pin = p;
		pin.address_in = bus;
	end

	// remembered so a floating wire never repeats its last value
	always @(posedge clk) begin
		last_bus <= bus;
	end

	// idle, deselected pins from time zero
	initial begin
		p = '0;
		p.chip_select_active_low = 1'b1;
		p.read_not_write = 1'b1;
		p.byte_lane_enables_n = 4'hF;
		{p.address_load_strobe_n, p.counter_advance_n, p.counter_clear_n} = 3'b111;
		p.counter_or_mask_select = 1'b1;
		drive = 1'b1;
		was_rb = 1'b0;
		last_bus = 18'h00000;
	end

	// one bus cycle: change after the rising edge, return at the falling edge
	task automatic cyc(input logic sel_on, input logic rd, input logic [3:0] be,
		input logic [2:0] ctl, input logic cm, input logic [17:0] a, input logic [35:0] d);
		logic rb;
		rb = (ctl[2:1] == 2'b01);
		@(posedge clk);
		drive <= !rb && !was_rb;
		was_rb <= rb;
		p.chip_select_active_low <= !sel_on;
		p.chip_select_active_high <= sel_on;
		p.read_not_write <= rd;
		p.byte_lane_enables_n <= be;
		{p.address_load_strobe_n, p.counter_advance_n, p.counter_clear_n} <= ctl;
		p.counter_or_mask_select <= cm;
		p.address_in <= a;
		p.data_in <= d;
		@(negedge clk);
	endtask

	task automatic idle();
		cyc(1'b0, 1'b1, 4'hF, 3'b111, 1'b1, 18'h00000, 36'h000000000);
	endtask

	// output enable moves at an edge but acts without one
	task automatic set_oe(input logic v);
		@(posedge clk);
		p.output_drive_enable_n <= v;
		@(negedge clk);
	endtask
endmodule

//--- verif/test_dual_port_ram_port_logic.sv
// self-checking testbench of the dual-port RAM port logic
`timescale 1ns/1ns
module test_dual_port_ram_port_logic;
	logic                   clk;
	logic                   reset_n;
	logic                   global_clear_n;
	logic             [3:0] reg_address;
	logic            [31:0] reg_write_data;
	logic                   reg_write;
	logic                   reg_read;
	logic            [31:0] reg_read_data;
	logic                   irq;
	dpr_pkg::dpr_port_in_t  left_in;
	dpr_pkg::dpr_port_in_t  right_in;
	dpr_pkg::dpr_port_out_t left_out;
	dpr_pkg::dpr_port_out_t right_out;
	int                     n_errors;
	int                     num_checks;

	// control codes {load strobe, advance, clear}, all active low
	localparam logic [2:0] LD = 3'b001;
	localparam logic [2:0] INC = 3'b101;
	localparam logic [2:0] RB = 3'b011;
	localparam logic [2:0] CLR = 3'b110;
	localparam logic [17:0] ADDRS [5] = '{18'h00000, 18'h00004, 18'h00005, 18'h00006, 18'h00007};
	localparam logic [2:0] OPS [6] = '{LD, INC, INC, INC, INC, CLR};
	localparam logic [17:0] EXP [6] = '{18'h00004, 18'h00005, 18'h00006, 18'h00007, 18'h00004,
		18'h00000};

	dpr_host u_left (.clk(clk), .pin(left_in), .pout(left_out));
	dpr_host u_right (.clk(clk), .pin(right_in), .pout(right_out));

	dpr_port_logic u_dut (
		.clk(clk), .reset_n(reset_n), .global_clear_n(global_clear_n),
		.left_in(left_in), .right_in(right_in), .left_out(left_out), .right_out(right_out),
		.reg_address(reg_address), .reg_write_data(reg_write_data), .reg_write(reg_write),
		.reg_read(reg_read), .reg_read_data(reg_read_data), .irq(irq)
	);

	// data pattern tied to its address so misrouted reads show
	function automatic logic [35:0] wd(input logic [17:0] a);
		return {a ^ 18'h2AAAA, a};
	endfunction

	task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] got);
		@(posedge clk);
		reg_address <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		got = reg_read_data;
	endtask

	task automatic wait_mbox(input logic v);
		for (int i = 0; i < 4 && right_out.mailbox_flag_n !== v; i++)
			@(negedge clk);
		check(right_out.mailbox_flag_n, v, "mailbox flag");
	endtask

	task automatic s_reset();
		logic [31:0] r;
		@(negedge clk);
		check(left_out.data_oe, 1'b0, "oe at reset");
		check(left_out.counter_wrap_flag_n, 1'b1, "wrap at reset");
		check(irq, 1'b0, "irq at reset");
		reg_rd(dpr_pkg::REG_STATE, r);
		check(r, 32'h0000000F, "state at reset");
		reg_rd(4'hC, r);
		check(r, 32'h00000000, "unmapped read");
	endtask

	task automatic s_rw();
		foreach (ADDRS[i])
			u_left.cyc(1'b1, 1'b0, 4'h0, LD, 1'b1, ADDRS[i], wd(ADDRS[i]));
		u_left.cyc(1'b1, 1'b1, 4'h0, LD, 1'b1, 18'h00005, 36'h000000000);
		u_left.idle();
		u_left.idle();
		check(left_out.data_out, wd(18'h00005), "read data");
		check(left_out.data_oe, 1'b1, "read drive");
		u_left.idle();
		check(left_out.data_oe, 1'b0, "deselect");
		repeat (3)
			u_left.cyc(1'b1, 1'b1, 4'h0, LD, 1'b1, 18'h00006, 36'h000000000);
		u_left.set_oe(1'b1);
		check(left_out.data_oe, 1'b0, "oe off");
		u_left.set_oe(1'b0);
		check(left_out.data_out, wd(18'h00006), "oe back");
		check(left_out.data_oe, 1'b1, "oe on");
		repeat (2)
			u_left.idle();
	endtask

	task automatic s_burst();
		int lows;
		logic [31:0] r;
		lows = 0;
		reg_wr(dpr_pkg::REG_MASK, 32'h00000001);
		// mask of 3 makes a four-word block
		u_left.cyc(1'b1, 1'b1, 4'h0, LD, 1'b0, 18'h00003, 36'h000000000);
		for (int i = 0; i < 8; i++) begin
			if (i < 6)
				u_left.cyc(1'b1, 1'b1, 4'h0, OPS[i], 1'b1, 18'h00004, 36'h000000000);
			else
				u_left.idle();
			lows += (left_out.counter_wrap_flag_n === 1'b0);
			if (i >= 2)
				check(left_out.data_out, wd(EXP[i-2]), "burst");
		end
		check(lows, 1, "wrap low count");
		check(irq, 1'b1, "wrap irq");
		reg_rd(dpr_pkg::REG_STATUS, r);
		check(r[3:0], 4'h1, "wrap status");
		reg_wr(dpr_pkg::REG_STATUS, 32'h00000001);
		@(negedge clk);
		check(irq, 1'b0, "irq cleared");
	endtask

	task automatic s_readback();
		u_left.cyc(1'b1, 1'b1, 4'h0, LD, 1'b1, 18'h12345, 36'h000000000);
		u_left.cyc(1'b1, 1'b1, 4'h0, RB, 1'b1, 18'h00000, 36'h000000000);
		u_left.idle();
		check(left_out.address_oe, 1'b1, "rb drive");
		check(left_out.address_out, 18'h12345, "rb count");
		u_left.idle();
		check(left_out.address_oe, 1'b0, "rb release");
		u_left.cyc(1'b1, 1'b1, 4'h0, RB, 1'b0, 18'h00000, 36'h000000000);
		u_left.idle();
		check(left_out.address_out, 18'h00003, "rb mask");
		u_left.idle();
	endtask

	task automatic s_cross();
		u_left.idle();
		u_left.cyc(1'b1, 1'b0, 4'h0, LD, 1'b1, 18'h00100, 36'h011111111);
		fork
			u_left.cyc(1'b1, 1'b0, 4'h0, LD, 1'b1, 18'h00100, 36'h987654321);
			u_right.cyc(1'b1, 1'b1, 4'h0, LD, 1'b1, 18'h00100, 36'h000000000);
		join
		fork
			u_left.idle();
			u_right.idle();
		join
		u_right.idle();
		check(right_out.data_out, 36'h987654321, "cross read");
	endtask

	task automatic s_mbox();
		logic [31:0] r;
		// a write with every lane off must leave the flag alone
		u_left.cyc(1'b1, 1'b0, 4'hF, LD, 1'b1, dpr_pkg::MBOX_RIGHT_ADDR, 36'h000000000);
		repeat (2)
			u_left.idle();
		check(right_out.mailbox_flag_n, 1'b1, "no lane");
		u_left.cyc(1'b1, 1'b0, 4'hE, LD, 1'b1, dpr_pkg::MBOX_RIGHT_ADDR, 36'h000000000);
		u_left.idle();
		wait_mbox(1'b0);
		check(left_out.mailbox_flag_n, 1'b1, "left flag");
		check(irq, 1'b0, "masked event");
		reg_rd(dpr_pkg::REG_STATUS, r);
		check(r[3:0], 4'h8, "mailbox status");
		u_right.cyc(1'b1, 1'b1, 4'h0, LD, 1'b1, dpr_pkg::MBOX_RIGHT_ADDR, 36'h000000000);
		u_right.idle();
		wait_mbox(1'b1);
	endtask

	// master clear mid-run wipes a pending left mailbox flag
	task automatic s_clear();
		logic [31:0] r;
		u_right.cyc(1'b1, 1'b0, 4'h0, LD, 1'b1, dpr_pkg::MBOX_LEFT_ADDR, 36'h000000000);
		u_right.idle();
		@(negedge clk);
		check(left_out.mailbox_flag_n, 1'b0, "left post");
		reg_rd(dpr_pkg::REG_STATUS, r);
		check(r[3:0], 4'hC, "both mbox status");
		@(posedge clk);
		global_clear_n <= 1'b0;
		@(posedge clk);
		global_clear_n <= 1'b1;
		@(negedge clk);
		check(left_out.mailbox_flag_n, 1'b1, "clear flag");
		reg_rd(dpr_pkg::REG_STATUS, r);
		check(r, 32'h00000000, "clear status");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard: a run past its limit counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("mismatch at %0t: run limit reached", $time);
		give_verdict();
	end

	initial begin
		n_errors = 0;
		num_checks = 0;
		reset_n = 1'b0;
		global_clear_n = 1'b1;
		reg_address = 4'h0;
		reg_write_data = 32'h00000000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		s_reset();
		s_rw();
		s_burst();
		s_readback();
		s_cross();
		s_mbox();
		s_clear();
		give_verdict();
	end
endmodule
